// >>> inc/fpps_pkg.sv
package fpps_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] FCTL_OFS = 8'h00;
   localparam logic [7:0] AUX1_OFS = 8'h04;
   localparam logic [7:0] AUX0_OFS = 8'h08;
   // flash_control_reg layout
   localparam int KEY_HI   = 7;
   localparam int KEY_LO   = 4;
   localparam int MAP_BIT  = 3;
   localparam int SEL_HI   = 2;
   localparam int SEL_LO   = 1;
   localparam int BUSY_BIT = 0;
   localparam logic [7:1] FCTL_RST = 7'h00;
   // aux_control_one / aux_control_zero bits
   localparam int BOOT_BIT = 0;
   localparam int XRAM_BIT = 0;
   localparam logic AUX_RST = 1'b0;
   // Launch key and space codes
   localparam logic [3:0] KEY_FIRST  = 4'h5;
   localparam logic [3:0] KEY_SECOND = 4'ha;
   localparam logic [1:0] SP_USER = 2'b00;
   localparam logic [1:0] SP_XPAGE = 2'b01;
   localparam logic [1:0] SP_SEC  = 2'b10;
   localparam logic [1:0] SP_RSVD = 2'b11;
   // Code space windows
   localparam logic [15:0] USER_TOP  = 16'h7fff;
   localparam logic [15:0] XPAGE_BASE = 16'hff80;
   localparam logic [15:0] BOOT_BASE = 16'hf800;
   localparam logic [15:0] SEC_ADDR  = 16'h0000;
   // Page geometry
   localparam int PAGE_BYTES = 128;
   localparam int IDX_W      = 7;
   localparam int PAGE_W     = 8;
   // Phase timing
   localparam int CLK_NS    = 8;
   localparam int ERASE_NS  = 2000;
   localparam int PROG_NS   = 2000;
   localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_CYC  = (PROG_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ERASE = 3'b010,
      ST_PROG  = 3'b100
   } fpps_state_t;
endpackage

// >>> inc/fpps_lat_if.sv
`timescale 1ns/10ps
interface fpps_lat_if;
   logic         wr;
   logic [6:0]   idx;
   logic [7:0]   page;
   logic [7:0]   data;
   logic         clr;
   logic [127:0] mask;
   logic [7:0]   page_q;
   logic [6:0]   rd_idx;
   logic [7:0]   rd_data;
   modport ctl (output wr, idx, page, data, clr, rd_idx, input mask, page_q, rd_data);
   modport lat (input wr, idx, page, data, clr, rd_idx, output mask, page_q, rd_data);
endinterface

// >>> verilog/fpps_latch.sv
`timescale 1ns/10ps
module fpps_latch (
   input wire logic hclk,
   input wire logic hresetn,
   fpps_lat_if.lat  lp
);
   logic [7:0] mem [0:fpps_pkg::PAGE_BYTES-1];

   genvar i;
   generate
      for (i = 0; i < fpps_pkg::PAGE_BYTES; i++) begin : g_ent
         wire hit = lp.wr && (lp.idx == 7'(i));
         // A load in the clearing cycle survives
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               lp.mask[i] <= 1'b0;
            end else if (hit) begin
               lp.mask[i] <= 1'b1; // [R11] [R12]
            end else if (lp.clr) begin
               lp.mask[i] <= 1'b0;
            end
         end
         always_ff @(posedge hclk) begin
            if (hit) begin
               mem[i] <= lp.data;
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lp.page_q  <= 8'h00;
         lp.rd_data <= 8'h00;
      end else begin
         if (lp.wr) begin
            lp.page_q <= lp.page; // [R13]
         end
         lp.rd_data <= mem[lp.rd_idx];
      end
   end

   a_page_last_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
      lp.wr |=> lp.page_q == $past(lp.page)) else $error("page not from last load");
   a_mask_loaded: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
      lp.wr |=> lp.mask[$past(lp.idx)]) else $error("loaded byte not marked");
endmodule // fpps_latch

// >>> verilog/fpps_key.sv
`timescale 1ns/10ps
module fpps_key (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       key_wr,
   input  wire logic [3:0] key_nib,
   input  wire logic       instr_start,
   output logic            launch
);
   logic armed;
   logic seen;

   wire first  = key_wr && (key_nib == fpps_pkg::KEY_FIRST);
   wire second = key_wr && (key_nib == fpps_pkg::KEY_SECOND) && armed;

   // The second key's own instruction start is the one start allowed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed  <= 1'b0;
         seen   <= 1'b0;
         launch <= 1'b0;
      end else begin
         launch <= second; // [R5]
         if (first) begin
            armed <= 1'b1; // [R5]
            seen  <= 1'b0;
         end else if (key_wr) begin
            armed <= 1'b0; // [R24]
         end else if (armed && instr_start) begin
            armed <= !seen; // [R7]
            seen  <= 1'b1;
         end
      end
   end

   a_key_abort: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
      armed && seen && instr_start && !key_wr |=> !armed) else $error("key not aborted");
   a_key_stray: assert property (@(posedge hclk) disable iff (!hresetn) // [R24] [R5]
      key_wr && !first && !second |=> !armed ##1 !launch) else $error("stray write launched");
   c_key_abort: cover property (@(posedge hclk) disable iff (!hresetn)
      armed ##1 !armed && !launch);
endmodule // fpps_key

// >>> verilog/fpps_top.sv
`timescale 1ns/10ps
// What this block does
// [R1] Latch-map bit steers data-space writes into the page column latches.
// [R2] Latch writes over the whole range; bits 6..0 byte, bits 14..7 page.
// [R3] Latch-map bit overrides the external-RAM select.
// [R4] Space field picks code reads: user, extra row, security byte; 11 reserved.
// [R5] Program only after key nibble 5 then A; the first write does nothing.
// [R6] Launch target follows space field; reserved code does nothing.
// [R7] Any instruction between the two key writes aborts the launch; the tracker lets one instruction start through and aborts on the second.
// [R8] Host keeps interrupts off while programming.
// [R9] Busy flag high during programming, low when done.
// [R10] Boot-map bit maps the boot array at F800h-FFFFh.
// [R11] Latches take from one byte to a whole 128-byte page.
// [R12] Erase only loaded bytes, then program them; others untouched.
// [R13] Page programmed is the page of the last latch write.
// [R14] Host loads latches, launches with 50h then A0h from boot code.
// [R15] Host loads extra row latches, launches with 52h then A2h.
// [R16] Host sets 0Ch, loads byte at 0000h, launches with 54h then A4h.
// [R17] After reset only the user array is readable, nothing else mapped.
// [R18] Host clears the control register when no mapping is needed.
// [R19] Value 02h maps the extra row at FF80h-FFFFh for reads.
// [R20] Value 04h maps the security byte at 0000h for reads.
// [R21] Control register: key 7..4, map 3, space 2..1, busy 0, reset zero.
// [R22] Software cannot change the busy flag.
// [R23] Launches only count while executing from the boot array.
// [R24] A control write that is neither key value disarms the tracker.
// [R25] Erase and program phases timed by counters; busy drops after both.
module fpps_top #(
   parameter int ERASE_CYCLES = fpps_pkg::ERASE_CYC,
   parameter int PROG_CYCLES  = fpps_pkg::PROG_CYC
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   input  wire logic         cpu_instr_start,
   input  wire logic         exec_from_boot,
   input  wire logic         dw_en,
   input  wire logic [15:0]  dw_addr,
   input  wire logic [7:0]   dw_data,
   output logic              xram_we,
   output logic              ext_we,
   input  wire logic [15:0]  cr_addr,
   output logic              cr_user,
   output logic              cr_xpage,
   output logic              cr_sec,
   output logic              cr_boot,
   output logic              cr_ext,
   output logic              fl_erase,
   output logic              fl_prog,
   output logic [1:0]        fl_target,
   output logic [7:0]        fl_page,
   output logic [127:0]      fl_mask,
   input  wire logic [6:0]   fl_rd_idx,
   output logic [7:0]        fl_rd_data
);
   fpps_lat_if lp ();

   fpps_pkg::fpps_state_t state;
   fpps_pkg::fpps_state_t next_state;

   logic [7:1]  fctl_q;
   logic        boot_map_bit;
   logic        external_ram_select;
   logic        dph_wr;
   logic [7:0]  dph_addr;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        launch;
   logic [15:0] busy_len;

   // Bus slave: single-cycle, always OKAY
   wire aph     = hsel && htrans[1] && hready;
   wire wr_fctl = dph_wr && (dph_addr == fpps_pkg::FCTL_OFS);
   wire wr_aux1 = dph_wr && (dph_addr == fpps_pkg::AUX1_OFS);
   wire wr_aux0 = dph_wr && (dph_addr == fpps_pkg::AUX0_OFS);

   wire       latch_map_bit      = fctl_q[fpps_pkg::MAP_BIT];
   wire [1:0] space_select_field = fctl_q[fpps_pkg::SEL_HI:fpps_pkg::SEL_LO];
   wire [3:0] launch_key_nibble  = fctl_q[fpps_pkg::KEY_HI:fpps_pkg::KEY_LO];
   wire       prog_busy_flag     = (state != fpps_pkg::ST_IDLE); // [R9]

   wire [7:0] fctl_rd = {fctl_q, prog_busy_flag}; // [R21]
   wire       rd_fctl = (haddr[7:0] == fpps_pkg::FCTL_OFS);
   wire       rd_aux1 = (haddr[7:0] == fpps_pkg::AUX1_OFS);
   wire       rd_aux0 = (haddr[7:0] == fpps_pkg::AUX0_OFS);
   wire [7:0] rd_mux  = rd_fctl ? fctl_rd :
                        rd_aux1 ? {7'h00, boot_map_bit} :
                        rd_aux0 ? {7'h00, external_ram_select} : 8'h00;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr   <= 1'b0;
         dph_addr <= 8'h00;
         hrdata   <= 32'h0000_0000;
      end else begin
         dph_wr   <= aph && hwrite;
         dph_addr <= haddr[7:0];
         hrdata   <= (aph && !hwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // Bit 0 is never stored, so software cannot touch busy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fctl_q              <= fpps_pkg::FCTL_RST; // [R21] [R17]
         boot_map_bit        <= fpps_pkg::AUX_RST;
         external_ram_select <= fpps_pkg::AUX_RST;
      end else begin
         if (wr_fctl) begin
            fctl_q <= hwdata[7:1]; // [R22]
         end
         if (wr_aux1) begin
            boot_map_bit <= hwdata[fpps_pkg::BOOT_BIT];
         end
         if (wr_aux0) begin
            external_ram_select <= hwdata[fpps_pkg::XRAM_BIT];
         end
      end
   end

   fpps_key i_fpps_key (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .key_wr      (wr_fctl),
      .key_nib     (hwdata[fpps_pkg::KEY_HI:fpps_pkg::KEY_LO]),
      .instr_start (cpu_instr_start),
      .launch      (launch)
   );

   // Space field is the one written with the second key
   wire launch_ok = launch && (space_select_field != fpps_pkg::SP_RSVD) // [R6]
                    && exec_from_boot // [R23]
                    && (state == fpps_pkg::ST_IDLE);

   // Data-space write routing
   assign lp.wr   = dw_en && latch_map_bit; // [R1] [R3]
   assign lp.idx  = dw_addr[6:0]; // [R2]
   assign lp.page = dw_addr[14:7]; // [R2]
   assign lp.data = dw_data;
   assign xram_we = dw_en && !latch_map_bit && !external_ram_select; // [R3]
   assign ext_we  = dw_en && !latch_map_bit && external_ram_select; // [R3]

   // Code-space read decode; boot window wins over everything
   wire in_boot = boot_map_bit && (cr_addr >= fpps_pkg::BOOT_BASE); // [R10]
   wire in_xpage = (space_select_field == fpps_pkg::SP_XPAGE)
                   && (cr_addr >= fpps_pkg::XPAGE_BASE); // [R19]
   wire in_sec   = (space_select_field == fpps_pkg::SP_SEC)
                   && (cr_addr == fpps_pkg::SEC_ADDR); // [R20]
   assign cr_boot  = in_boot;
   assign cr_xpage = !in_boot && in_xpage; // [R4]
   assign cr_sec   = !in_boot && in_sec; // [R4]
   assign cr_user  = !in_boot && !in_xpage && !in_sec
                     && (cr_addr <= fpps_pkg::USER_TOP); // [R4] [R17]
   assign cr_ext   = !in_boot && !in_xpage && !in_sec
                    && (cr_addr > fpps_pkg::USER_TOP);

   // Sequencer: erase loaded bytes, then program them
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         fpps_pkg::ST_IDLE: begin
            if (launch_ok) begin
               next_state = fpps_pkg::ST_ERASE; // [R12]
               next_cnt   = 16'(ERASE_CYCLES - 1); // [R25]
            end
         end
         fpps_pkg::ST_ERASE: begin
            if (cnt == 16'h0000) begin
               next_state = fpps_pkg::ST_PROG; // [R12]
               next_cnt   = 16'(PROG_CYCLES - 1); // [R25]
            end else begin
               next_cnt = cnt - 16'h0001;
            end
         end
         fpps_pkg::ST_PROG: begin
            if (cnt == 16'h0000) begin
               next_state = fpps_pkg::ST_IDLE; // [R25] [R9]
            end else begin
               next_cnt = cnt - 16'h0001;
            end
         end
         default: begin
            next_state = fpps_pkg::ST_IDLE;
            next_cnt   = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= fpps_pkg::ST_IDLE;
         cnt   <= 16'h0000;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Target and page are frozen at launch so later loads cannot move them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fl_erase  <= 1'b0;
         fl_prog   <= 1'b0;
         fl_target <= fpps_pkg::SP_USER;
         fl_page   <= 8'h00;
      end else begin
         fl_erase <= (next_state == fpps_pkg::ST_ERASE);
         fl_prog  <= (next_state == fpps_pkg::ST_PROG);
         if (launch_ok) begin
            fl_target <= space_select_field; // [R6]
            fl_page   <= lp.page_q; // [R13]
         end
      end
   end

   // Only loaded bytes are touched; the mask empties when done, except bytes loaded in the clearing cycle
   assign lp.clr     = (state == fpps_pkg::ST_PROG) && (cnt == 16'h0000); // [R12]
   assign lp.rd_idx  = fl_rd_idx;
   assign fl_mask    = lp.mask; // [R12]
   assign fl_rd_data = lp.rd_data;

   fpps_latch i_fpps_latch (
      .hclk    (hclk),
      .hresetn (hresetn),
      .lp      (lp)
   );

   // Helper: length of each busy stretch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_len <= 16'h0000;
      end else if (prog_busy_flag) begin
         busy_len <= busy_len + 16'h0001;
      end else begin
         busy_len <= 16'h0000;
      end
   end

   localparam int BUSY_TOTAL = ERASE_CYCLES + PROG_CYCLES;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_latch_route: assert property ( // [R1] [R3]
      dw_en && latch_map_bit |-> lp.wr && !xram_we && !ext_we)
      else $error("write not sent to latches");
   a_launch_busy: assert property ( // [R5] [R9]
      launch_ok |=> prog_busy_flag && fl_erase)
      else $error("launch did not start busy");
   a_busy_length: assert property ( // [R25] [R9]
      $fell(prog_busy_flag) |-> busy_len == 16'(BUSY_TOTAL))
      else $error("busy length wrong");
   a_erase_first: assert property ( // [R12]
      $rose(fl_prog) |-> $past(fl_erase))
      else $error("program before erase");
   a_reserved_none: assert property ( // [R6]
      launch && !prog_busy_flag && space_select_field == fpps_pkg::SP_RSVD |=> !prog_busy_flag)
      else $error("reserved code launched");
   a_user_boot_only: assert property ( // [R23]
      launch && !prog_busy_flag && !exec_from_boot |=> !prog_busy_flag)
      else $error("launch outside boot code");
   a_busy_sw_write: assert property ( // [R22]
      !prog_busy_flag && !launch_ok ##1 wr_fctl && !launch |=> !prog_busy_flag)
      else $error("software changed busy");
   a_boot_window: assert property ( // [R10]
      boot_map_bit && cr_addr >= fpps_pkg::BOOT_BASE |-> cr_boot && !cr_xpage && !cr_user)
      else $error("boot array not mapped");
   a_sec_read: assert property ( // [R20] [R4]
      !boot_map_bit && space_select_field == fpps_pkg::SP_SEC && cr_addr == 16'h0000
      |-> cr_sec && !cr_user)
      else $error("security byte not mapped");
   a_reset_user: assert property ( // [R17]
      fctl_q == 7'h00 && !boot_map_bit && cr_addr <= fpps_pkg::USER_TOP |-> cr_user)
      else $error("user array not default");
   a_key_stored: assert property ( // [R21]
      wr_fctl |=> launch_key_nibble == $past(hwdata[fpps_pkg::KEY_HI:fpps_pkg::KEY_LO]))
      else $error("key nibble not stored");

   c_user_prog: cover property (launch_ok && space_select_field == fpps_pkg::SP_USER);
   c_xpage_read: cover property (cr_xpage);
   c_full_cycle: cover property ($fell(prog_busy_flag));
endmodule // fpps_top

// >>> test/fpps_cpu_model.sv
`timescale 1ns/10ps
// Boot-resident CPU: bus master, data-space writes, instruction starts
// Interrupts are never enabled, so no exit from programming mode
module fpps_cpu_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             cpu_instr_start,
   output logic             dw_en,
   output logic [15:0]      dw_addr,
   output logic [7:0]       dw_data
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h00000000;
      cpu_instr_start = 1'b0;
      dw_en = 1'b0;
      dw_addr = 16'h0000;
      dw_data = 8'h00;
   end
   task automatic bus(input logic [7:0] o, input logic w, input logic [7:0] d,
                      output logic [31:0] q);
      // Callers may come off-edge; requests always start on an edge
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, o};
      hwrite <= w;
      hsize <= 3'b010;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      // Released data bus must not look like the last value
      hwdata <= ~{24'h000000, d};
   endtask
   // One pulse per instruction; more than one between keys is an intrusion
   task automatic instr(input int n);
      repeat (n) begin
         cpu_instr_start <= 1'b1;
         @(posedge hclk);
         cpu_instr_start <= 1'b0;
         @(posedge hclk);
      end
   endtask
   task automatic dwr(input logic [15:0] a, input logic [7:0] d);
      dw_en <= 1'b1;
      dw_addr <= a;
      dw_data <= d;
      @(posedge hclk);
      dw_en <= 1'b0;
      dw_data <= ~d;
      @(posedge hclk);
   endtask
   task automatic launch(input logic [1:0] sel, input int gap, input logic [3:0] mid);
      logic [31:0] q;
      bus(fpps_pkg::FCTL_OFS, 1'b1, {4'h5, 1'b0, sel, 1'b0}, q);
      if (mid != 4'h0) bus(fpps_pkg::FCTL_OFS, 1'b1, {mid, 1'b0, sel, 1'b0}, q);
      instr(gap);
      bus(fpps_pkg::FCTL_OFS, 1'b1, {4'ha, 1'b0, sel, 1'b0}, q);
   endtask
endmodule // fpps_cpu_model

// >>> test/tb_flash_page_program_sequencer.sv
`timescale 1ns/10ps
module tb_flash_page_program_sequencer;
   localparam int EC = 4;
   localparam int PC = 8;
   localparam logic [7:0] FC = fpps_pkg::FCTL_OFS;
   localparam logic [7:0] A1 = fpps_pkg::AUX1_OFS;
   localparam logic [7:0] A0 = fpps_pkg::AUX0_OFS;
   logic          hclk = 1'b0;
   logic          hresetn = 1'b0;
   logic          hsel, hwrite, hreadyout, hresp, cpu_instr_start, dw_en;
   logic [31:0]   haddr, hwdata, hrdata, q;
   logic [1:0]    htrans, fl_target;
   logic [2:0]    hsize;
   logic [15:0]   dw_addr;
   logic [7:0]    dw_data, fl_page, fl_rd_data;
   logic          xram_we, ext_we, cr_user, cr_xpage, cr_sec, cr_boot, cr_ext;
   logic          fl_erase, fl_prog;
   logic [127:0]  fl_mask;
   logic [127:0]  em = 128'h0;
   logic [15:0]   cr_addr = 16'h1234;
   logic [6:0]    fl_rd_idx = 7'h00;
   logic          exec_from_boot = 1'b1;
   int            n_mismatch = 0;
   int            tests_run = 0;
   int            cyc = 0;

   fpps_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) i_fpps_top (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_instr_start,
      .exec_from_boot, .dw_en, .dw_addr, .dw_data, .xram_we, .ext_we, .cr_addr,
      .cr_user, .cr_xpage, .cr_sec, .cr_boot, .cr_ext, .fl_erase, .fl_prog,
      .fl_target, .fl_page, .fl_mask, .fl_rd_idx, .fl_rd_data);
   fpps_cpu_model i_fpps_cpu_model (
      .hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .cpu_instr_start, .dw_en, .dw_addr, .dw_data);

   always #4 hclk = ~hclk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Runs take under a thousand cycles; the ceiling only catches a hang
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      i_fpps_cpu_model.bus(o, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] o, input logic [7:0] e, input string nm);
      i_fpps_cpu_model.bus(o, 1'b0, 8'h00, q);
      chk(nm, e, q);
   endtask
   task automatic cr(input logic [15:0] a, input logic [4:0] e);
      cr_addr <= a;
      #1;
      chk("code_src", e, {cr_user, cr_xpage, cr_sec, cr_boot, cr_ext});
      @(posedge hclk);
   endtask
   task automatic dwc(input logic [15:0] a, input logic [1:0] e);
      fork
         i_fpps_cpu_model.dwr(a, 8'h5a);
         begin
            #2;
            chk("data_we", e, {xram_we, ext_we});
         end
      join
   endtask
   task automatic t_reset();
      rd(FC, 8'h00, "flash_ctl");
      rd(A1, 8'h00, "aux1");
      rd(8'h0c, 8'h00, "unmapped");
      cr(16'h1234, 5'b10000);
      chk("hresp", 1'b0, hresp);
      $display("test reset done");
   endtask
   task automatic t_regs();
      wr(FC, 8'h0f);
      rd(FC, 8'h0e, "flash_ctl_busy_ro");
      wr(A0, 8'h01);
      rd(A0, 8'h01, "aux0");
      wr(A0, 8'h00);
      wr(FC, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_map();
      wr(FC, 8'h02);
      cr(16'hff80, 5'b01000);
      wr(FC, 8'h04);
      cr(16'h0000, 5'b00100);
      wr(FC, 8'h00);
      cr(16'h0000, 5'b10000);
      wr(A1, 8'h01);
      cr(16'hf800, 5'b00010);
      wr(A1, 8'h00);
      $display("test map done");
   endtask
   task automatic t_data();
      dwc(16'h0100, 2'b10);
      wr(A0, 8'h01);
      dwc(16'h0100, 2'b01);
      wr(FC, 8'h08);
      dwc(16'h0100, 2'b00);
      em[0] = 1'b1;
      wr(FC, 8'h00);
      wr(A0, 8'h00);
      $display("test data path done");
   endtask
   // Load two latch bytes, then launch; go says whether programming must run
   task automatic prog(input logic [1:0] sel, input logic [15:0] a1, a2, input int gap,
                       input logic [3:0] mid, input logic boot, input logic go);
      int n;
      exec_from_boot <= boot;
      wr(FC, {4'h0, 1'b1, sel, 1'b0});
      i_fpps_cpu_model.dwr(a1, 8'h3c);
      i_fpps_cpu_model.dwr(a2, 8'hc3);
      em[a1[6:0]] = 1'b1;
      em[a2[6:0]] = 1'b1;
      fl_rd_idx <= a2[6:0];
      repeat (2) @(posedge hclk);
      #1;
      chk("mask", em, fl_mask);
      chk("latch_data", 8'hc3, fl_rd_data);
      i_fpps_cpu_model.launch(sel, gap, mid);
      repeat (2) @(posedge hclk);
      #1;
      chk("erase_start", go, fl_erase);
      if (go) begin
         chk("target", sel, fl_target);
         chk("page", a2[14:7], fl_page);
         // One erase cycle has already passed at this point
         n = 1;
         while (fl_erase === 1'b1 && n < 99) begin
            @(posedge hclk);
            #1;
            n++;
         end
         chk("erase_len", EC, n);
         chk("prog_start", 1'b1, fl_prog);
         i_fpps_cpu_model.bus(FC, 1'b0, 8'h00, q);
         chk("busy", 1'b1, q[0]);
         #1;
         n = 3;
         while (fl_prog === 1'b1 && n < 99) begin
            @(posedge hclk);
            #1;
            n++;
         end
         chk("prog_len", PC, n);
         i_fpps_cpu_model.bus(FC, 1'b0, 8'h00, q);
         chk("busy_clear", 1'b0, q[0]);
         em = 128'h0;
      end
      chk("mask_after", em, fl_mask);
      exec_from_boot <= 1'b1;
      wr(FC, 8'h00);
      $display("test program space %0d done", sel);
   endtask
   task automatic t_half();
      wr(FC, 8'h50);
      repeat (4) @(posedge hclk);
      #1;
      chk("half_key", 1'b0, fl_erase);
      wr(FC, 8'h00);
      $display("test single key done");
   endtask

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_regs();
      t_map();
      t_data();
      prog(fpps_pkg::SP_USER, 16'h0100, 16'h01ff, 1, 4'h0, 1'b1, 1'b1);
      prog(fpps_pkg::SP_XPAGE, 16'hff80, 16'hffff, 1, 4'h0, 1'b1, 1'b1);
      prog(fpps_pkg::SP_SEC, 16'h0000, 16'h0000, 1, 4'h0, 1'b1, 1'b1);
      prog(fpps_pkg::SP_RSVD, 16'h0100, 16'h0101, 1, 4'h0, 1'b1, 1'b0);
      prog(fpps_pkg::SP_USER, 16'h0202, 16'h0203, 2, 4'h0, 1'b1, 1'b0);
      prog(fpps_pkg::SP_USER, 16'h0204, 16'h0205, 1, 4'h3, 1'b1, 1'b0);
      prog(fpps_pkg::SP_USER, 16'h0206, 16'h0207, 1, 4'h0, 1'b0, 1'b0);
      t_half();
      finish_test();
   end
endmodule // tb_flash_page_program_sequencer
